/* File: pbc_pkg.sv */
// Constants, state codes and pin bundle of the push-button power controller.
// Assumes one 100 MHz clock; analog comparators sit outside this logic.
//
// How it works
// - Enable rises on a button press only while supply is above threshold.
// - A power-button press in normal operation drives the interrupt low.
// - Undervoltage in normal operation also drives the interrupt low.
// - A long push pulses reset or drops enable, chosen by variant.
// - A separate active-low flag shows supply below the upper threshold.
// - Button-state output shows the debounced power button, masked during undervoltage and held for the minimum interrupt time for presses in normal operation.
// - Hold-confirm pull-down is on while off and during start-up, off in operation.
// - Each button passes glitch rejection, falling-edge detect and debounce.
// - The power-button status appears on a dedicated output.
// - Blanking expiry without hold-confirm releases the enable output.
// - Hold-confirm going low in normal operation drops the enable output.
// - Hold-to-start variant aborts start-up when the button is released early.
package pbc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  // Least times round up, the blanking window (a longest time) rounds down.
  localparam int unsigned GLITCH_NS = 1000;
  localparam int unsigned GLITCH_CYC =
    (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_MS = 30;
  localparam int unsigned DEBOUNCE_CYC =
    (DEBOUNCE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_MS = 1000;
  localparam int unsigned BLANK_CYC = BLANK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned INT_MIN_MS = 30;
  localparam int unsigned INT_MIN_CYC =
    (INT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_MS = 200;
  localparam int unsigned REC_CYC =
    (REC_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Slots of the synchronised level inputs.
  localparam int unsigned SYN_SUPPLY = 0;
  localparam int unsigned SYN_HOLD = 1;
  localparam int unsigned SYN_CAP_DONE = 2;
  localparam int unsigned SYN_CAP_FITTED = 3;
  localparam int unsigned SYN_COUNT = 4;

  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_START = 2'h1,
    ST_RUN = 2'h3,
    ST_LONG = 2'h2
  } pbc_state_t;

  typedef struct packed {
    logic power_enable;
    logic reset_n;
    logic interrupt_n;
    logic undervoltage_flag_n;
    logic button_state_out_n;
    logic hold_pulldown_en;
  } pbc_pins_t;

  localparam pbc_pins_t PINS_RESET = '{
    power_enable: 1'h0,
    reset_n: 1'h0,
    interrupt_n: 1'h1,
    undervoltage_flag_n: 1'h1,
    button_state_out_n: 1'h1,
    hold_pulldown_en: 1'h1
  };

endpackage

/* File: pbc_button_filter.sv */
// Glitch filter, falling-edge detector and debouncer for one button pin.
// Assumes an active-low button pin from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module pbc_button_filter
  import pbc_pkg::*;
#(
  parameter int unsigned GLITCH = GLITCH_CYC,
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic btn_n,
  output logic pressed,
  output logic press_evt
);

  localparam int unsigned GW = $clog2(GLITCH + 1);
  localparam int unsigned DW = $clog2(DEBOUNCE + 1);

  logic [2:0] sync_ff, nxt_sync;
  logic filt_ff, nxt_filt;
  logic [GW-1:0] glt_ff, nxt_glt;
  logic [DW-1:0] deb_ff, nxt_deb;
  logic armed_ff, nxt_armed;
  logic pressed_ff, nxt_pressed;
  logic evt_ff, nxt_evt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_sync = {sync_ff[1:0], btn_n};
    nxt_filt = filt_ff;
    nxt_glt = '0;
    nxt_deb = deb_ff;
    nxt_armed = armed_ff;
    nxt_pressed = pressed_ff;
    nxt_evt = 1'h0;
    // A new level counts once stages two and three agree for GLITCH cycles.
    if (sync_ff[1] == sync_ff[2] && sync_ff[2] != filt_ff) begin
      if (glt_ff == GW'(GLITCH - 1)) begin
        nxt_filt = sync_ff[2];
      end else begin
        nxt_glt = glt_ff + GW'(1);
      end
    end
    if (filt_ff && !nxt_filt) begin
      nxt_armed = 1'h1;
      nxt_deb = '0;
    end else if (nxt_filt) begin
      nxt_armed = 1'h0;
      nxt_pressed = 1'h0;
    end else if (armed_ff) begin
      if (deb_ff == DW'(DEBOUNCE - 1)) begin
        nxt_armed = 1'h0;
        nxt_pressed = 1'h1;
        nxt_evt = 1'h1;
      end else begin
        nxt_deb = deb_ff + DW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_ff <= 3'h7;
      filt_ff <= 1'h1;
      glt_ff <= '0;
      deb_ff <= '0;
      armed_ff <= 1'h0;
      pressed_ff <= 1'h0;
      evt_ff <= 1'h0;
    end else if (ce) begin
      sync_ff <= nxt_sync;
      filt_ff <= nxt_filt;
      glt_ff <= nxt_glt;
      deb_ff <= nxt_deb;
      armed_ff <= nxt_armed;
      pressed_ff <= nxt_pressed;
      evt_ff <= nxt_evt;
    end
  end

  assign pressed = pressed_ff;
  assign press_evt = evt_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  debounce_full_a: assert property (
    $rose(pressed_ff) |-> !filt_ff && $past(armed_ff) && evt_ff)
    else $error("press taken without a debounced falling edge");

endmodule // pbc_button_filter

`default_nettype wire

/* File: pbc_power_controller.sv */
// Start-up, run and long-push sequencing of the push-button power controller.
// Assumes comparator levels and button pins arrive unsynchronised.
`timescale 1ns/1ps
`default_nettype none

module pbc_power_controller
  import pbc_pkg::*;
#(
  parameter int unsigned GLITCH = GLITCH_CYC,
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC,
  parameter int unsigned BLANK = BLANK_CYC,
  parameter int unsigned INT_MIN = INT_MIN_CYC,
  parameter int unsigned REC = REC_CYC,
  parameter bit LONG_PUSH_DISABLES_EN = 1'b0,
  parameter bit HOLD_TO_START = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic power_button_n,
  input wire logic second_button_n,
  input wire logic hold_confirm_in,
  input wire logic upper_supply_threshold,
  input wire logic long_push_delay_cap,
  input wire logic long_push_delay_cap_fitted,
  output pbc_pins_t pins
);

  localparam int unsigned BW = $clog2(BLANK + 1);
  localparam int unsigned IW = $clog2(INT_MIN + 1);
  localparam int unsigned RW = $clog2(REC + 1);
  // Synchroniser reset levels match the idle pins, so no false undervoltage
  // shows in the first cycles after reset.
  localparam logic [SYN_COUNT-1:0] SYN_RST = SYN_COUNT'(1) << SYN_SUPPLY;

  logic [SYN_COUNT-1:0] raw;
  logic [SYN_COUNT-1:0] lvl;
  logic pb_pressed, pb_evt, sr_pressed;
  logic supply_ok, hold_ok, long_done, both, running;

  pbc_state_t state_ff, nxt_state;
  logic [BW-1:0] blank_ff, nxt_blank;
  logic [IW-1:0] int_ff, nxt_int;
  logic [RW-1:0] rec_ff, nxt_rec;
  pbc_pins_t pins_ff, nxt_pins;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; a level changes when stages two and three
  // agree.
  assign raw[SYN_SUPPLY] = upper_supply_threshold;
  assign raw[SYN_HOLD] = hold_confirm_in;
  assign raw[SYN_CAP_DONE] = long_push_delay_cap;
  assign raw[SYN_CAP_FITTED] = long_push_delay_cap_fitted;

  genvar gi;
  generate
    for (gi = 0; gi < SYN_COUNT; gi++) begin : g_sync
      logic [2:0] sy_ff, nxt_sy;
      logic lv_ff, nxt_lv;
      always_comb begin
        nxt_sy = {sy_ff[1:0], raw[gi]};
        nxt_lv = (sy_ff[1] == sy_ff[2]) ? sy_ff[2] : lv_ff;
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sy_ff <= {3{SYN_RST[gi]}};
          lv_ff <= SYN_RST[gi];
        end else if (ce) begin
          sy_ff <= nxt_sy;
          lv_ff <= nxt_lv;
        end
      end
      assign lvl[gi] = lv_ff;
    end
  endgenerate

  pbc_button_filter #(
    .GLITCH(GLITCH),
    .DEBOUNCE(DEBOUNCE)
  ) u_pb (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .btn_n(power_button_n),
    .pressed(pb_pressed),
    .press_evt(pb_evt)
  );

  pbc_button_filter #(
    .GLITCH(GLITCH),
    .DEBOUNCE(DEBOUNCE)
  ) u_sr (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .btn_n(second_button_n),
    .pressed(sr_pressed),
    .press_evt()
  );

  assign supply_ok = lvl[SYN_SUPPLY];
  assign hold_ok = lvl[SYN_HOLD];
  assign both = pb_pressed && sr_pressed;
  // Without a delay capacitor the extra long-push delay is zero.
  assign long_done = !lvl[SYN_CAP_FITTED] || lvl[SYN_CAP_DONE];
  assign running = (state_ff == ST_RUN) || (state_ff == ST_LONG);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_blank = blank_ff;
    nxt_int = int_ff;
    nxt_rec = rec_ff;
    if (rec_ff != '0) begin
      nxt_rec = rec_ff - RW'(1);
    end
    if (int_ff != '0) begin
      nxt_int = int_ff - IW'(1);
    end
    // Presses seen during undervoltage are ignored by the status logic.
    if (running && pb_evt && supply_ok) begin
      nxt_int = IW'(INT_MIN);
    end
    unique case (state_ff)
      ST_OFF: begin
        if (pb_evt && supply_ok) begin
          nxt_state = ST_START;
          nxt_blank = BW'(BLANK - 1);
          nxt_rec = RW'(REC);
        end
      end
      ST_START: begin
        if (hold_ok) begin
          nxt_state = ST_RUN;
        end else if (blank_ff == '0) begin
          nxt_state = ST_OFF;
        end else if (HOLD_TO_START && !pb_pressed) begin
          nxt_state = ST_OFF;
        end else begin
          nxt_blank = blank_ff - BW'(1);
        end
      end
      ST_RUN: begin
        if (!hold_ok) begin
          nxt_state = ST_OFF;
        // The press event itself has not started the minimum time yet.
        end else if (both && int_ff == '0 && !pb_evt) begin
          nxt_state = ST_LONG;
        end
      end
      ST_LONG: begin
        if (!hold_ok) begin
          nxt_state = ST_OFF;
        end else if (!both) begin
          nxt_state = ST_RUN;
        end else if (long_done) begin
          if (LONG_PUSH_DISABLES_EN) begin
            nxt_state = ST_OFF;
          end else begin
            // Reset pulse, then the host must confirm again within blanking.
            nxt_state = ST_START;
            nxt_blank = BW'(BLANK - 1);
            nxt_rec = RW'(REC);
          end
        end
      end
    endcase
  end

  always_comb begin
    nxt_pins.power_enable = (nxt_state != ST_OFF);
    nxt_pins.reset_n = (nxt_state != ST_OFF) && (nxt_rec == '0);
    nxt_pins.interrupt_n = !(((nxt_state == ST_RUN) ||
      (nxt_state == ST_LONG)) && ((nxt_int != '0) || !supply_ok ||
      (pb_pressed && supply_ok)));
    nxt_pins.undervoltage_flag_n = supply_ok;
    nxt_pins.button_state_out_n =
      !((nxt_int != '0) || (pb_pressed && supply_ok));
    nxt_pins.hold_pulldown_en =
      (nxt_state == ST_OFF) || (nxt_state == ST_START);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_OFF;
      blank_ff <= '0;
      int_ff <= '0;
      rec_ff <= '0;
      pins_ff <= PINS_RESET;
    end else if (ce) begin
      state_ff <= nxt_state;
      blank_ff <= nxt_blank;
      int_ff <= nxt_int;
      rec_ff <= nxt_rec;
      pins_ff <= nxt_pins;
    end
  end

  assign pins = pins_ff;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  en_needs_supply_a: assert property (
    $rose(pins_ff.power_enable) |-> $past(supply_ok) && $past(pb_evt))
    else $error("enable rose without supply or press");

  press_irq_a: assert property (
    ce && state_ff == ST_RUN && hold_ok && pb_evt && supply_ok
    |=> !pins_ff.interrupt_n && !pins_ff.button_state_out_n)
    else $error("button press gave no interrupt");

  uv_irq_a: assert property (
    ce && state_ff == ST_RUN && hold_ok && !supply_ok |=> !pins_ff.interrupt_n)
    else $error("undervoltage gave no interrupt");

  long_push_a: assert property (
    ce && state_ff == ST_LONG && hold_ok && both && long_done
    |=> (LONG_PUSH_DISABLES_EN ? !pins_ff.power_enable : !pins_ff.reset_n))
    else $error("long push had no effect");

  long_wait_a: assert property (
    ce && state_ff == ST_RUN && (int_ff != '0 || pb_evt)
    |=> state_ff != ST_LONG)
    else $error("long push taken before the minimum interrupt time");

  uv_flag_a: assert property (
    ce && !supply_ok ##1 ce && !supply_ok |-> !pins_ff.undervoltage_flag_n)
    else $error("undervoltage flag not low");

  pulldown_phase_a: assert property (
    pins_ff.hold_pulldown_en == (state_ff == ST_OFF || state_ff == ST_START))
    else $error("hold pull-down in wrong phase");

  blank_expire_a: assert property (
    ce && state_ff == ST_START && !hold_ok && blank_ff == '0
    |=> !pins_ff.power_enable && state_ff == ST_OFF)
    else $error("blanking expiry kept enable");

  hold_drop_a: assert property (
    ce && running && !hold_ok |=> !pins_ff.power_enable)
    else $error("hold-confirm low kept enable");

  early_release_a: assert property (
    HOLD_TO_START && ce && state_ff == ST_START && !hold_ok && !pb_pressed
    |=> !pins_ff.power_enable)
    else $error("early release did not abort start");

  irq_min_a: assert property (
    $rose(int_ff != '0) |-> int_ff == IW'(INT_MIN))
    else $error("interrupt minimum counter misloaded");

  no_cap_a: assert property (
    ce && state_ff == ST_LONG && hold_ok && both && !lvl[SYN_CAP_FITTED]
    |=> state_ff != ST_LONG)
    else $error("long push waited without a delay capacitor");

endmodule // pbc_power_controller

`default_nettype wire

/* File: pbc_host_model.sv */
// Host processor model that confirms start-up on the hold-confirm line.
// Assumes the controller's power-enable and pull-down outputs as inputs.
`timescale 1ns/1ps
`default_nettype none

module pbc_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_enable,
  input wire logic hold_pulldown_en,
  input wire logic confirm,
  input wire logic [7:0] delay,
  input wire logic shut,
  output logic hold_confirm_in
);
  logic [7:0] cnt_ff;
  logic last_ff;
  logic drv_hi;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 8'h00;
      last_ff <= 1'b0;
    end else begin
      cnt_ff <= !power_enable ? 8'h00 : cnt_ff + {7'h00, cnt_ff != 8'hFF};
      last_ff <= hold_confirm_in;
    end
  end

  // Confirms only once the chosen delay after enable has passed.
  assign drv_hi = power_enable && confirm && !shut && cnt_ff >= delay;
  // An undriven line sits at the pull-down or wanders without it.
  assign hold_confirm_in = drv_hi ? 1'b1 :
    (shut || hold_pulldown_en) ? 1'b0 : ~last_ff;
endmodule // pbc_host_model

`default_nettype wire

/* File: tb_push_button_power_controller.sv */
// Self-checking bench of the push-button power controller.
// Assumes the host model file and small cycle counts for the delays.
`timescale 1ns/1ps
`default_nettype none

module tb_push_button_power_controller;
  import pbc_pkg::*;
  localparam int EN = 5;
  localparam int RS = 4;
  localparam int IR = 3;
  localparam int UV = 2;
  localparam int BS = 1;
  localparam int PD = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pb_n = 1'b1;
  logic sb_n = 1'b1;
  logic supply = 1'b1;
  logic cap = 1'b0;
  logic fitted = 1'b0;
  logic confirm = 1'b1;
  logic [7:0] delay = 8'h14;
  logic shut = 1'b0;
  logic ce = 1'b1;
  wire logic hold;
  pbc_pins_t pins;
  wire logic [5:0] pv;
  int err_total = 0;
  int total_checks = 0;
  int n;

  assign pv = pins;
  always #5 clk = ~clk;

  pbc_power_controller #(.GLITCH(2), .DEBOUNCE(8), .BLANK(200),
    .INT_MIN(20), .REC(10)) DUT (.clk(clk), .rst(rst), .ce(ce),
    .power_button_n(pb_n), .second_button_n(sb_n), .hold_confirm_in(hold),
    .upper_supply_threshold(supply), .long_push_delay_cap(cap),
    .long_push_delay_cap_fitted(fitted), .pins(pins));

  pbc_host_model host (.clk(clk), .rst(rst), .power_enable(pins.power_enable),
    .hold_pulldown_en(pins.hold_pulldown_en), .confirm(confirm),
    .delay(delay), .shut(shut), .hold_confirm_in(hold));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic check(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wait_bit(input int idx, input logic v, input int lim,
    input string nm);
    int i;
    i = 0;
    while (pv[idx] !== v && i < lim) begin
      cyc(1);
      i++;
    end
    check(nm, {7'h00, pv[idx]}, {7'h00, v});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h3fc8));
    cyc(6);
    rst = 1'b0;
    cyc(1);
    check("pins_reset", {2'h0, pv}, {2'h0, PINS_RESET});
    // Short dips on the button must not start the supply.
    for (int k = 0; k < 4; k++) begin
      pb_n = 1'b0;
      cyc(1 + $urandom % 5);
      pb_n = 1'b1;
      cyc(30);
      check("glitch_en", {7'h00, pv[EN]}, 8'h00);
    end
    $display("test glitch done");
    supply = 1'b0;
    pb_n = 1'b0;
    cyc(40);
    check("low_supply_en", {7'h00, pv[EN]}, 8'h00);
    pb_n = 1'b1;
    supply = 1'b1;
    cyc(30);
    $display("test low supply done");
    delay = 8'(20 + $urandom % 100);
    pb_n = 1'b0;
    wait_bit(EN, 1'b1, 40, "start_en");
    check("start_rst", {7'h00, pv[RS]}, 8'h00);
    check("start_pd", {7'h00, pv[PD]}, 8'h01);
    wait_bit(PD, 1'b0, 200, "run_pd");
    pb_n = 1'b1;
    check("run_en", {7'h00, pv[EN]}, 8'h01);
    wait_bit(RS, 1'b1, 20, "run_rst");
    cyc(30);
    // A supply dip while the clock enable is low must leave no trace.
    ce = 1'b0;
    supply = 1'b0;
    cyc(5 + $urandom % 10);
    check("ce_hold_uv", {7'h00, pv[UV]}, 8'h01);
    supply = 1'b1;
    ce = 1'b1;
    cyc(10);
    check("ce_back_uv", {7'h00, pv[UV]}, 8'h01);
    $display("test start done");
    pb_n = 1'b0;
    wait_bit(IR, 1'b0, 40, "press_int");
    check("press_state", {7'h00, pv[BS]}, 8'h00);
    pb_n = 1'b1;
    wait_bit(BS, 1'b1, 60, "state_back");
    wait_bit(IR, 1'b1, 60, "int_back");
    $display("test interrupt done");
    supply = 1'b0;
    wait_bit(UV, 1'b0, 10, "uv_flag");
    wait_bit(IR, 1'b0, 10, "uv_int");
    check("uv_state", {7'h00, pv[BS]}, 8'h01);
    supply = 1'b1;
    wait_bit(UV, 1'b1, 10, "uv_clear");
    wait_bit(IR, 1'b1, 60, "uv_int_back");
    $display("test undervoltage done");
    for (int f = 0; f < 2; f++) begin
      fitted = f[0];
      cyc(10);
      pb_n = 1'b0;
      sb_n = 1'b0;
      if (f == 1) begin
        cyc(60 + $urandom % 20);
        check("cap_wait_rst", {7'h00, pv[RS]}, 8'h01);
        cap = 1'b1;
      end else begin
        cyc(25);
        check("long_min_rst", {7'h00, pv[RS]}, 8'h01);
      end
      wait_bit(RS, 1'b0, 80, "long_rst");
      pb_n = 1'b1;
      sb_n = 1'b1;
      cap = 1'b0;
      wait_bit(RS, 1'b1, 40, "long_rst_end");
      check("long_en", {7'h00, pv[EN]}, 8'h01);
      wait_bit(PD, 1'b0, 40, "long_pd");
      cyc(30);
    end
    $display("test long push done");
    shut = 1'b1;
    wait_bit(EN, 1'b0, 10, "hold_low_en");
    shut = 1'b0;
    cyc(30);
    $display("test shutdown done");
    confirm = 1'b0;
    pb_n = 1'b0;
    wait_bit(EN, 1'b1, 40, "blank_en");
    n = 0;
    while (pv[EN] === 1'b1 && n < 260) begin
      cyc(1);
      n++;
    end
    check("blank_len", {7'h00, n >= 190 && n <= 210}, 8'h01);
    pb_n = 1'b1;
    cyc(30);
    $display("test blanking done");
    confirm = 1'b1;
    delay = 8'h96;
    pb_n = 1'b0;
    wait_bit(EN, 1'b1, 40, "early_en");
    cyc(5);
    pb_n = 1'b1;
    wait_bit(EN, 1'b0, 30, "early_drop");
    $display("test early release done");
    stop_test();
  end

  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule // tb_push_button_power_controller

`default_nettype wire
